//--- bench/ties_chk.sv
// Purpose: port-level timing checks for the timer interrupt flag block
// Assumes: single clock domain, bound to ties_top
// Notes:   requests are two registers away from their cause
`timescale 1ns/10ps
module ties_chk
    import ties_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // timer state
    input wire logic [15:0] timer_count,
    input wire logic [15:0] general_reg_a,
    input wire logic [15:0] general_reg_b,
    input wire logic [15:0] general_reg_c,
    input wire logic [15:0] general_reg_d,
    input wire logic [3:0]  chan_capture_mode,
    input wire logic [3:0]  chan_capture_strobe,
    // requests
    input wire logic        overflow_irq_request,
    input wire logic        chan_d_irq_request,
    input wire logic        chan_c_irq_request,
    input wire logic        chan_b_irq_request,
    input wire logic        chan_a_irq_request,
    // register bus
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic [7:0]  araddr,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic [15:0] cnt_q;
    logic        bprev_q;
    logic [4:0]  ev;
    logic [4:0]  rq;
    logic        bw;
    logic        rtk;
    always_ff @(posedge aclk) begin
        cnt_q   <= timer_count;
        bprev_q <= bvalid;
    end
    // compare is taken as plain equality: looser than first-cycle, never fires falsely
    assign ev[4] = (cnt_q == TIES_COUNT_MAX) && (timer_count == TIES_COUNT_ZERO);
    assign ev[3] = chan_capture_mode[3] ? chan_capture_strobe[3] : (timer_count == general_reg_d);
    assign ev[2] = chan_capture_mode[2] ? chan_capture_strobe[2] : (timer_count == general_reg_c);
    assign ev[1] = chan_capture_mode[1] ? chan_capture_strobe[1] : (timer_count == general_reg_b);
    assign ev[0] = chan_capture_mode[0] ? chan_capture_strobe[0] : (timer_count == general_reg_a);
    assign rq  = {overflow_irq_request, chan_d_irq_request, chan_c_irq_request, chan_b_irq_request,
                  chan_a_irq_request};
    assign bw  = bvalid && !bprev_q;
    assign rtk = arvalid && arready;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence b_answer;
        !bvalid ##1 bvalid;
    endsequence

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    for (genvar g = 0; g < 5; g++) begin : gen_req
        chk_req_rise: assert property ($rose(rq[g]) |-> $past(ev[g], 2) || $past(bw))
            else $error("request rose without event or write");
        chk_req_fall: assert property ($fell(rq[g]) |-> $past(bw))
            else $error("request fell without register write");
    end
    chk_b_delay: assert property (wr_take |=> b_answer)
        else $error("write response not two edges after take");
    chk_ready_low: assert property (wr_take |=> (!awready && !wready) [*2])
        else $error("write readies rose before response");
    chk_r_delay: assert property (rtk |=> rvalid && !arready)
        else $error("read answer late");
    chk_rsvd_ones: assert property (rtk && araddr <= TIES_OFS_STATUS && araddr[1:0] == 2'h0
        |=> rdata[6:4] == 3'h7)
        else $error("reserved bits not read as one");
    chk_err_resp: assert property (rtk && araddr > TIES_OFS_MASK |=> rresp == TIES_RESP_SLVERR)
        else $error("unmapped read not refused");
    chk_upper_zero: assert property (rtk && araddr <= TIES_OFS_MASK |=> rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
endmodule : ties_chk

bind ties_top ties_chk u_chk (.aclk, .aresetn, .timer_count, .general_reg_a, .general_reg_b, .general_reg_c,
    .general_reg_d, .chan_capture_mode, .chan_capture_strobe, .overflow_irq_request, .chan_d_irq_request,
    .chan_c_irq_request, .chan_b_irq_request, .chan_a_irq_request, .awvalid, .awready, .wvalid, .wready,
    .bvalid, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid);

//--- bench/timer_irq_enable_status_bench.sv
// Purpose: register-level test of the timer interrupt flag block
// Assumes: readies idle high, aw and w taken together
// Notes:   all waits bounded at 50 cycles
`timescale 1ns/10ps
module timer_irq_enable_status_bench;
    import ties_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [15:0] timer_count, general_reg_a, general_reg_b, general_reg_c, general_reg_d;
    logic [3:0]  chan_capture_mode, chan_capture_strobe, wstrb;
    logic        overflow_irq_request, chan_d_irq_request, chan_c_irq_request, chan_b_irq_request;
    logic        chan_a_irq_request, irq, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [31:0] reqs;
    int          n_mismatch = 0, tests_run = 0, i;

    always #5 aclk = ~aclk;
    assign reqs = {27'h0, overflow_irq_request, chan_d_irq_request, chan_c_irq_request,
                   chan_b_irq_request, chan_a_irq_request};

    ties_top u_ties_top (.aclk, .aresetn, .timer_count, .general_reg_a, .general_reg_b, .general_reg_c,
        .general_reg_d, .chan_capture_mode, .chan_capture_strobe, .overflow_irq_request, .chan_d_irq_request,
        .chan_c_irq_request, .chan_b_irq_request, .chan_a_irq_request, .irq, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready);

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic fail_if_late(input int n);
        if (n >= 50) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask : fail_if_late

    // bounded wait on one answer: 0 bvalid, 1 arready, 2 rvalid
    task automatic wait_on(input int sel);
        int   n;
        logic s;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            s = (sel == 0) ? bvalid : ((sel == 1) ? arready : rvalid);
            if (s === 1'b1) break;
        end
        fail_if_late(n);
    endtask : wait_on

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        bit aw_up;
        bit w_up;
        aw_up   = 1'b1;
        w_up    = 1'b1;
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        // each channel is let go at the edge that takes it
        for (n = 0; n < 50 && (aw_up || w_up); n++) begin
            @(posedge aclk);
            if (aw_up && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_up = 1'b0;
            end
            if (w_up && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_up = 1'b0;
            end
        end
        fail_if_late(n);
        wait_on(0);
        bready  <= 1'b0;
        check("bresp", {30'h0, bresp}, {30'h0, er});
        // idle edge: the next call must not re-raise bready in this step
        @(posedge aclk);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        wait_on(1);
        arvalid <= 1'b0;
        wait_on(2);
        rready  <= 1'b0;
        check("rdata", rdata, exp);
        check("rresp", {30'h0, rresp}, {30'h0, er});
        @(posedge aclk);
    endtask : rchk

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        timer_count = 16'h1234;
        general_reg_a = 16'h0100;
        general_reg_b = 16'h0101;
        general_reg_c = 16'h0102;
        general_reg_d = 16'h0103;
        {chan_capture_mode, chan_capture_strobe} = 8'h00;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk(TIES_OFS_ENABLE, 32'h70, TIES_RESP_OKAY);
        rchk(TIES_OFS_STATUS, 32'h70, TIES_RESP_OKAY);
        rchk(TIES_OFS_MASK, 32'h00, TIES_RESP_OKAY);
        wr(TIES_OFS_ENABLE, 8'h8F, TIES_RESP_OKAY);
        rchk(TIES_OFS_ENABLE, 32'hFF, TIES_RESP_OKAY);
        timer_count <= 16'hFFFF;
        tick(1);
        timer_count <= 16'h0000;
        tick(3);
        check("requests", reqs, 32'h10);
        wr(TIES_OFS_STATUS, 8'h00, TIES_RESP_OKAY);
        rchk(TIES_OFS_STATUS, 32'hF0, TIES_RESP_OKAY);
        wr(TIES_OFS_STATUS, 8'h70, TIES_RESP_OKAY);
        tick(2);
        check("requests", reqs, 32'h00);
        rchk(TIES_OFS_STATUS, 32'h70, TIES_RESP_OKAY);
        for (i = 0; i < 4; i++) begin
            timer_count <= 16'h0100 + 16'(i);
            tick(1);
        end
        timer_count <= 16'h2000;
        tick(3);
        check("requests", reqs, 32'h0F);
        rchk(TIES_OFS_STATUS, 32'h7F, TIES_RESP_OKAY);
        wr(TIES_OFS_STATUS, 8'hFF, TIES_RESP_OKAY);
        rchk(TIES_OFS_STATUS, 32'h7F, TIES_RESP_OKAY);
        wr(TIES_OFS_STATUS, 8'h71, TIES_RESP_OKAY);
        rchk(TIES_OFS_STATUS, 32'h71, TIES_RESP_OKAY);
        wr(TIES_OFS_STATUS, 8'h70, TIES_RESP_OKAY);
        rchk(TIES_OFS_STATUS, 32'h70, TIES_RESP_OKAY);
        chan_capture_mode <= 4'hF;
        for (i = 0; i < 4; i++) begin
            chan_capture_strobe <= 4'(1 << i);
            tick(1);
        end
        chan_capture_strobe <= 4'h0;
        timer_count <= 16'hFFFF;
        tick(1);
        timer_count <= 16'h0000;
        tick(3);
        rchk(TIES_OFS_STATUS, 32'hFF, TIES_RESP_OKAY);
        // one enable bit at a time: only its own request may stand
        for (i = 0; i < 5; i++) begin
            wr(TIES_OFS_ENABLE, (i == 4) ? 8'h80 : 8'(1 << i), TIES_RESP_OKAY);
            tick(2);
            check("requests", reqs, 32'(1 << i));
        end
        wr(TIES_OFS_ENABLE, 8'h00, TIES_RESP_OKAY);
        tick(2);
        check("requests", reqs, 32'h00);
        rchk(TIES_OFS_EVENT, 32'h8F, TIES_RESP_OKAY);
        check("irq", {31'h0, irq}, 32'h0);
        wr(TIES_OFS_MASK, 8'h01, TIES_RESP_OKAY);
        tick(2);
        check("irq", {31'h0, irq}, 32'h1);
        wr(TIES_OFS_EVENT, 8'h01, TIES_RESP_OKAY);
        tick(2);
        check("irq", {31'h0, irq}, 32'h0);
        rchk(TIES_OFS_EVENT, 32'h8E, TIES_RESP_OKAY);
        wr(TIES_OFS_MASK, 8'h80, TIES_RESP_OKAY);
        tick(2);
        check("irq", {31'h0, irq}, 32'h1);
        rchk(8'h10, 32'h00, TIES_RESP_SLVERR);
        wr(8'h10, 8'hFF, TIES_RESP_SLVERR);
        // byte lane 0 off: the write is answered but must not land
        wstrb <= 4'h0;
        wr(TIES_OFS_ENABLE, 8'hFF, TIES_RESP_OKAY);
        wstrb <= 4'hF;
        rchk(TIES_OFS_ENABLE, 32'h70, TIES_RESP_OKAY);
        report_and_stop();
    end
endmodule : timer_irq_enable_status_bench

//--- shared/ties_pkg.sv
// Purpose: constants for the timer interrupt enable/status block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses in the low 8 bits
// Notes:   flag vectors are 5 bits wide, index 4 is the overflow flag

package ties_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] TIES_OFS_ENABLE = 8'h00;
    localparam logic [7:0] TIES_OFS_STATUS = 8'h04;
    localparam logic [7:0] TIES_OFS_EVENT  = 8'h08;
    localparam logic [7:0] TIES_OFS_MASK   = 8'h0C;

    // ------------------------------------------------------------
    // field positions in the 8-bit registers
    // ------------------------------------------------------------
    localparam int TIES_BIT_OVF   = 7;
    localparam int TIES_BIT_CHD   = 3;
    localparam int TIES_BIT_CHC   = 2;
    localparam int TIES_BIT_CHB   = 1;
    localparam int TIES_BIT_CHA   = 0;
    localparam int TIES_NUM_CHAN  = 4;
    localparam int TIES_FLAG_OVF  = 4;

    // reserved bits 6..4 of the enable and status registers read as one
    localparam logic [7:0] TIES_RSVD_ONES = 8'h70;

    // ------------------------------------------------------------
    // reset values and bus answers
    // ------------------------------------------------------------
    localparam logic [4:0]  TIES_FLAG_RESET = 5'h00;
    localparam logic [15:0] TIES_COUNT_MAX  = 16'hFFFF;
    localparam logic [15:0] TIES_COUNT_ZERO = 16'h0000;
    localparam logic [1:0]  TIES_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  TIES_RESP_SLVERR = 2'h2;

endpackage : ties_pkg

//--- verilog/ties_top.sv
// Purpose: interrupt enable and status flags of a 16-bit four-channel timer
// Assumes: counter, general registers and capture strobes come from logic on aclk
// Notes:   AXI4-Lite slave, one write and one read in flight at most

`timescale 1ns/10ps

module ties_top
    import ties_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // timer state
    input  wire logic [15:0] timer_count,
    input  wire logic [15:0] general_reg_a,
    input  wire logic [15:0] general_reg_b,
    input  wire logic [15:0] general_reg_c,
    input  wire logic [15:0] general_reg_d,
    input  wire logic [3:0]  chan_capture_mode,
    input  wire logic [3:0]  chan_capture_strobe,
    // interrupt requests
    output logic             overflow_irq_request,
    output logic             chan_d_irq_request,
    output logic             chan_c_irq_request,
    output logic             chan_b_irq_request,
    output logic             chan_a_irq_request,
    output logic             irq,
    // write address channel
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // write data channel
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // write response channel
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // read address channel
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    // read data channel
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [4:0]  flag_q;
    logic [4:0]  flag_d;
    logic [4:0]  armed_q;
    logic [4:0]  enable_q;
    logic [4:0]  event_q;
    logic [4:0]  event_d;
    logic [4:0]  mask_q;
    logic [4:0]  set_ev;
    logic [3:0]  match_q;
    logic [3:0]  match_now;
    logic [15:0] count_prev_q;
    logic [15:0] gr_sel [TIES_NUM_CHAN];
    logic        awready_q;
    logic        wready_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        arready_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [7:0]  waddr_q;
    logic [7:0]  wbyte_q;
    logic        wlane_q;
    logic        aw_have_q;
    logic        w_have_q;
    logic        aw_hs;
    logic        w_hs;
    logic        b_hs;
    logic        ar_hs;
    logic        r_hs;
    logic        do_write;
    logic        wr_en;
    logic        wr_status;
    logic        wr_event;
    logic        rd_status;
    logic [7:0]  status_view;
    logic [7:0]  enable_view;
    logic [4:0]  clr_req;

    // pack the flag vector into the register layout
    function automatic logic [7:0] ties_pack(input logic [4:0] v);
        ties_pack = {v[TIES_FLAG_OVF], 3'h0, v[3:0]};
    endfunction : ties_pack

    function automatic logic [4:0] ties_unpack(input logic [7:0] b);
        ties_unpack = {b[TIES_BIT_OVF], b[3:0]};
    endfunction : ties_unpack

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    assign gr_sel[TIES_BIT_CHA] = general_reg_a;
    assign gr_sel[TIES_BIT_CHB] = general_reg_b;
    assign gr_sel[TIES_BIT_CHC] = general_reg_c;
    assign gr_sel[TIES_BIT_CHD] = general_reg_d;

    // a match is flagged on its first cycle only, so a slow counter
    // resting on the compare value does not set the flag again after a clear
    for (genvar i = 0; i < TIES_NUM_CHAN; i++) begin : g_chan
        assign match_now[i] = (timer_count == gr_sel[i]) && !chan_capture_mode[i];
        assign set_ev[i]    = (match_now[i] && !match_q[i])
                            || (chan_capture_mode[i] && chan_capture_strobe[i]);
    end

    assign set_ev[TIES_FLAG_OVF] = (count_prev_q == TIES_COUNT_MAX)
                                 && (timer_count == TIES_COUNT_ZERO);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_q      <= 4'h0;
            count_prev_q <= TIES_COUNT_ZERO;
        end else begin
            match_q      <= match_now;
            count_prev_q <= timer_count;
        end
    end

    // ------------------------------------------------------------
    // bus handshakes
    // ------------------------------------------------------------
    assign aw_hs     = awvalid && awready_q;
    assign w_hs      = wvalid && wready_q;
    assign b_hs      = bvalid_q && bready;
    assign ar_hs     = arvalid && arready_q;
    assign r_hs      = rvalid_q && rready;
    assign do_write  = aw_have_q && w_have_q && !bvalid_q;
    assign wr_en     = do_write && wlane_q;
    assign wr_status = wr_en && (waddr_q == TIES_OFS_STATUS);
    assign wr_event  = wr_en && (waddr_q == TIES_OFS_EVENT);
    assign rd_status = ar_hs && (araddr == TIES_OFS_STATUS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            aw_have_q <= 1'b0;
            waddr_q   <= 8'h00;
        end else if (aw_hs) begin
            awready_q <= 1'b0;
            aw_have_q <= 1'b1;
            waddr_q   <= awaddr;
        end else if (b_hs) begin
            awready_q <= 1'b1;
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_q <= 1'b1;
            w_have_q <= 1'b0;
            wbyte_q  <= 8'h00;
            wlane_q  <= 1'b0;
        end else if (w_hs) begin
            wready_q <= 1'b0;
            w_have_q <= 1'b1;
            wbyte_q  <= wdata[7:0];
            wlane_q  <= wstrb[0];
        end else if (b_hs) begin
            wready_q <= 1'b1;
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= TIES_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            case (waddr_q)
                TIES_OFS_ENABLE, TIES_OFS_STATUS,
                TIES_OFS_EVENT, TIES_OFS_MASK: bresp_q <= TIES_RESP_OKAY;
                default:                       bresp_q <= TIES_RESP_SLVERR;
            endcase
        end else if (b_hs) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    assign status_view = ties_pack(flag_q) | TIES_RSVD_ONES;
    assign enable_view = ties_pack(enable_q) | TIES_RSVD_ONES;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= TIES_RESP_OKAY;
        end else if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= TIES_RESP_OKAY;
            case (araddr)
                TIES_OFS_ENABLE: rdata_q <= {24'h00_0000, enable_view};
                TIES_OFS_STATUS: rdata_q <= {24'h00_0000, status_view};
                TIES_OFS_EVENT:  rdata_q <= {24'h00_0000, ties_pack(event_q)};
                TIES_OFS_MASK:   rdata_q <= {24'h00_0000, ties_pack(mask_q)};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= TIES_RESP_SLVERR;
                end
            endcase
        end else if (r_hs) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // enable and mask registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_q <= TIES_FLAG_RESET;
        end else if (wr_en && (waddr_q == TIES_OFS_ENABLE)) begin
            enable_q <= ties_unpack(wbyte_q);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= TIES_FLAG_RESET;
        end else if (wr_en && (waddr_q == TIES_OFS_MASK)) begin
            mask_q <= ties_unpack(wbyte_q);
        end
    end

    // ------------------------------------------------------------
    // status flags with read-then-write-zero clear
    // ------------------------------------------------------------
    // a zero written to a bit clears it only if that bit was read as one
    // by an earlier status read; writing one leaves the flag alone
    assign clr_req = wr_status ? (armed_q & ~ties_unpack(wbyte_q)) : 5'h00;

    // hardware set wins over a clear in the same cycle
    assign flag_d = (flag_q & ~clr_req) | set_ev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_q <= TIES_FLAG_RESET;
        end else begin
            flag_q <= flag_d;
        end
    end

    // arming is used up by a status write with byte lane 0 on unless a status read is taken in the same cycle, so each clear needs a fresh read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed_q <= TIES_FLAG_RESET;
        end else if (rd_status) begin
            armed_q <= flag_q;
        end else if (wr_status) begin
            armed_q <= TIES_FLAG_RESET;
        end
    end

    // ------------------------------------------------------------
    // interrupt requests
    // ------------------------------------------------------------
    ties_req_gate u_req_ovf (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .flag      (flag_q[TIES_FLAG_OVF]),
        .enable    (enable_q[TIES_FLAG_OVF]),
        .request_q (overflow_irq_request)
    );

    ties_req_gate u_req_chd (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .flag      (flag_q[TIES_BIT_CHD]),
        .enable    (enable_q[TIES_BIT_CHD]),
        .request_q (chan_d_irq_request)
    );

    ties_req_gate u_req_chc (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .flag      (flag_q[TIES_BIT_CHC]),
        .enable    (enable_q[TIES_BIT_CHC]),
        .request_q (chan_c_irq_request)
    );

    ties_req_gate u_req_chb (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .flag      (flag_q[TIES_BIT_CHB]),
        .enable    (enable_q[TIES_BIT_CHB]),
        .request_q (chan_b_irq_request)
    );

    ties_req_gate u_req_cha (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .flag      (flag_q[TIES_BIT_CHA]),
        .enable    (enable_q[TIES_BIT_CHA]),
        .request_q (chan_a_irq_request)
    );

    // sticky event log, write one to clear, set wins
    assign event_d = (wr_event ? (event_q & ~ties_unpack(wbyte_q)) : event_q) | set_ev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_q <= TIES_FLAG_RESET;
            irq     <= 1'b0;
        end else begin
            event_q <= event_d;
            irq     <= |(event_q & mask_q);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign awready = awready_q;
    assign wready  = wready_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = arready_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

endmodule : ties_top

// ------------------------------------------------------------
// request gate: flag and enable, registered
// ------------------------------------------------------------
module ties_req_gate #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // flag and its enable
    input  wire logic [WIDTH-1:0] flag,
    input  wire logic [WIDTH-1:0] enable,
    // gated request
    output logic      [WIDTH-1:0] request_q
);

    // registered so the request pin never glitches while flag and enable change
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            request_q <= '0;
        end else begin
            request_q <= flag & enable;
        end
    end

endmodule : ties_req_gate
